// [pkg/bcc_pkg.sv]
// shared types, cycle codes and register map of the bus command controller
package bcc_pkg;

   // cycle type, encoded as {memory/io select, status one, status zero}
   typedef enum logic [2:0] {
      CYC_IRQ_ACK_STROBE   = 3'h0,
      CYC_IORD   = 3'h1,
      CYC_IOWR   = 3'h2,
      CYC_IDLE0  = 3'h3,
      CYC_HALT   = 3'h4,
      CYC_MEMRD  = 3'h5,
      CYC_MEMWR  = 3'h6,
      CYC_IDLE1  = 3'h7
   } bcc_cyc_t;

   // internal bus states; the command state is two clocks long, status one
   typedef enum logic [1:0] {BS_IDLE, BS_STATUS, BS_CMD} bcc_bus_state_t;

   // pins coming in from the processor side, all asynchronous to pclk
   typedef struct packed {
      logic mem_io_select;
      logic status_line_one_n;
      logic status_line_zero_n;
      logic compat_timing_strap;
      logic latched_controller_select;
      logic command_delay;
      logic ready_n;
      logic shared_enable_input;
   } bcc_pin_in_t;

   // command strobes, active low
   typedef struct packed {
      logic irq_ack_strobe_n;
      logic io_read_strobe_n;
      logic io_write_strobe_n;
      logic mem_read_strobe_n;
      logic mem_write_strobe_n;
   } bcc_cmd_t;

   // state shown to software
   typedef struct packed {
      bcc_bus_state_t state;
      bcc_cyc_t       cyc;
      logic           selected;
      logic           compat;
      logic           cmd_on;
   } bcc_stat_t;

   localparam int unsigned PIN_W      = $bits(bcc_pin_in_t);
   localparam int unsigned CMD_W      = $bits(bcc_cmd_t);
   localparam int unsigned STAT_W     = $bits(bcc_stat_t);

   // synchroniser reset value: status lines idle high, so reset opens no cycle
   localparam bcc_pin_in_t PIN_RST    = '{status_line_one_n: 1'b1, status_line_zero_n: 1'b1,
                                          default: 1'b0};

   // command start delay in clocks counted from the first command clock
   localparam logic [1:0]  DLY_FAST   = 2'h0;
   localparam logic [1:0]  DLY_CMP_RD = 2'h1;
   localparam logic [1:0]  DLY_CMP_WR = 2'h2;
   localparam logic [1:0]  CNT_MAX    = 2'h3;

   // register map
   localparam int unsigned ADDR_W     = 8;
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_STATUS = 8'h04;
   localparam logic [7:0]  REG_CYCLES = 8'h08;
   localparam logic [7:0]  REG_WAITS  = 8'h0C;
   localparam int unsigned CTRL_EN    = 0;
   localparam int unsigned CTRL_CLR   = 1;
   localparam logic        CTRL_EN_RST = 1'h1;

   // decode of the three select lines, used for every new cycle
   function automatic bcc_cyc_t decode_cycle(input bcc_pin_in_t p);
      return bcc_cyc_t'({p.mem_io_select, p.status_line_one_n, p.status_line_zero_n});
   endfunction

   function automatic logic is_read(input bcc_cyc_t c);
      return (c == CYC_IRQ_ACK_STROBE) || (c == CYC_IORD) || (c == CYC_MEMRD);
   endfunction

   function automatic logic is_write(input bcc_cyc_t c);
      return (c == CYC_IOWR) || (c == CYC_MEMWR);
   endfunction

endpackage

// [design/bcc_sync.sv]
// two flip-flop synchroniser for a group of asynchronous pins
module bcc_sync #(
   parameter int unsigned  W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_ff;

   // first stage feeds only the second stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_ff <= RST;
         q       <= RST;
      end
      else if (clk_en)
      begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end

endmodule

// [design/bcc_regs.sv]
// apb slave holding control, status and cycle counters
module bcc_regs (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  clk_en,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire bcc_pkg::bcc_stat_t    stat,
   input  wire logic                  ev_cycle,
   input  wire logic                  ev_wait
);

   logic        count_en_ff;
   logic        staged_ff;
   logic [31:0] cycles_ff;
   logic [31:0] waits_ff;
   logic        mapped;
   logic        wr_ctrl;
   logic        clr;
   logic [31:0] rd_mux;

   // address decode and read mux
   always_comb
   begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         bcc_pkg::REG_CTRL:   rd_mux[bcc_pkg::CTRL_EN] = count_en_ff;
         bcc_pkg::REG_STATUS: rd_mux[bcc_pkg::STAT_W-1:0] = stat;
         bcc_pkg::REG_CYCLES: rd_mux = cycles_ff;
         bcc_pkg::REG_WAITS:  rd_mux = waits_ff;
         default:             mapped = 1'b0;
      endcase
   end

   // read data staged one cycle ahead, so the answer waits only while clk_en is low
   assign pready  = clk_en & staged_ff;
   assign pslverr = pready & psel & penable & ~mapped;
   assign wr_ctrl = pready & psel & penable & pwrite & (paddr == bcc_pkg::REG_CTRL);
   assign clr     = wr_ctrl & pwdata[bcc_pkg::CTRL_CLR];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         staged_ff <= 1'b0;
         prdata    <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         staged_ff <= psel & ~(penable & staged_ff);
         prdata    <= mapped ? rd_mux : 32'h0000_0000;
      end
   end

   // control register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_en_ff <= bcc_pkg::CTRL_EN_RST;
      else if (wr_ctrl)
         count_en_ff <= pwdata[bcc_pkg::CTRL_EN];
   end

   // counters; an event in the clearing cycle is still counted
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cycles_ff <= 32'h0000_0000;
         waits_ff  <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         cycles_ff <= (clr ? 32'h0000_0000 : cycles_ff) + {31'h0, ev_cycle & count_en_ff};
         waits_ff  <= (clr ? 32'h0000_0000 : waits_ff) + {31'h0, ev_wait & count_en_ff};
      end
   end

endmodule

// [design/bcc_ctrl.sv]
// bus command controller: status decode, command strobes and transceiver control
//
// Functional notes
// - inputs sampled and outputs changed only on the controller clock edge
// - either status line low at an edge starts a new bus cycle
// - cycle type decoded from memory/io select and the two status lines
// - memory/io select low means io space, high means memory space
// - strap high gives compatible timing, low gives fast timing
// - controller select captured at end of status state; low ignores cycle
// - command delay high holds command off, resampled each clock
// - ready low before any command still ends the bus cycle
// - command delay never touches the control outputs
// - ready low ends a cycle; compatible writes need one wait state
// - ready held low through reset; controller comes up idle
// - compatible mode: enable is bus grant; high floats commands, kills data
// - fast mode: enable low forces commands and data enable inactive, driven
// - shared enable is asynchronous and synchronised before use
// - address latch strobe on every cycle but halt, never suppressed
// - cascade enable only in interrupt acknowledge, ignores control inputs
// - compatible mode raises transceiver enable later in write cycles
// - direction high for writes and when idle, low for reads
// - transceiver enable is off whenever direction changes
// - one strobe each for acknowledge, io read/write, memory read/write
// - timing mode and delay start a strobe, ready ends it
// - idle, status and command states each last two clocks; here idle and status last one
// - ready sampled at end of command state; high repeats it as a wait state, the delay count running on
// - compatible: reads one clock later, writes two, write enable one
// - address latch strobe in second half of status, off at its end
module bcc_ctrl (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  clk_en,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire bcc_pkg::bcc_pin_in_t  pins,
   output bcc_pkg::bcc_cmd_t          cmd,
   output logic                       cmd_oe,
   output logic                       addr_latch_strobe,
   output logic                       cascade_enable,
   output logic                       transceiver_enable,
   output logic                       transfer_direction
);

   bcc_pkg::bcc_pin_in_t    pin_s;
   bcc_pkg::bcc_bus_state_t st_ff;
   bcc_pkg::bcc_bus_state_t nxt_st;
   bcc_pkg::bcc_cyc_t       cyc_ff;
   bcc_pkg::bcc_cyc_t       nxt_cyc;
   bcc_pkg::bcc_cmd_t       nxt_cmd;
   bcc_pkg::bcc_stat_t      stat;
   logic                    phase_ff;
   logic                    nxt_phase;
   logic [1:0]              cnt_ff;
   logic [1:0]              nxt_cnt;
   logic                    sel_ff;
   logic                    nxt_sel;
   logic                    cmd_on_ff;
   logic                    nxt_cmd_on;
   logic                    nxt_oe;
   logic                    nxt_ale;
   logic                    nxt_cas;
   logic                    xen_ff;
   logic                    nxt_xen;
   logic                    dir_ff;
   logic                    nxt_dir;
   logic                    start;
   logic                    cycle_end;
   logic                    wait_st;
   logic                    compat;
   logic                    enable_ok;
   logic [1:0]              need;
   logic                    want_xen;
   logic                    want_dir;
   logic                    sel_now;
   logic [bcc_pkg::CMD_W-1:0] onehot;

   // every pin crosses two flops first, the shared enable among them
   bcc_sync #(
      .W       (bcc_pkg::PIN_W),
      .RST     (bcc_pkg::PIN_RST) // idle levels: a zero reset would fake an acknowledge
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .d       (pins),
      .q       (pin_s)
   );

   // software view and counters
   assign stat.state    = st_ff;
   assign stat.cyc      = cyc_ff;
   assign stat.selected = sel_ff;
   assign stat.compat   = compat;
   assign stat.cmd_on   = cmd_on_ff;

   bcc_regs u_regs (
      .pclk     (pclk),
      .presetn  (presetn),
      .clk_en   (clk_en),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pwdata   (pwdata),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .stat     (stat),
      .ev_cycle (cycle_end),
      .ev_wait  (wait_st)
   );

   // the strap is read live; it is assumed stable, so no capture is kept
   assign compat = pin_s.compat_timing_strap;

   // a cycle opens when either status line is low
   assign start = ~pin_s.status_line_zero_n | ~pin_s.status_line_one_n;

   // end of a command state with ready low closes the cycle, command or not
   assign cycle_end = (st_ff == bcc_pkg::BS_CMD) & phase_ff & ~pin_s.ready_n;

   // end of a command state with ready high repeats it as a wait state
   assign wait_st = (st_ff == bcc_pkg::BS_CMD) & phase_ff & pin_s.ready_n;

   // enable meaning depends on the strap: grant low, or command enable high
   assign enable_ok = compat ? ~pin_s.shared_enable_input
                             : pin_s.shared_enable_input;

   // bus state sequencing; idle and status count as one clock each here,
   // the other half being the sampling edge of the status lines
   always_comb
   begin
      nxt_st    = st_ff;
      nxt_phase = phase_ff;
      nxt_cnt   = cnt_ff;
      nxt_cyc   = cyc_ff;
      nxt_sel   = sel_ff;
      unique case (st_ff)
         bcc_pkg::BS_IDLE:
         begin
            nxt_phase = ~phase_ff;
            if (start)
            begin
               nxt_st    = bcc_pkg::BS_STATUS;
               nxt_phase = 1'b1;
               nxt_cyc   = bcc_pkg::decode_cycle(pin_s);
            end
         end
         bcc_pkg::BS_STATUS:
         begin
            nxt_st    = bcc_pkg::BS_CMD;
            nxt_phase = 1'b0;
            nxt_cnt   = 2'h0;
            nxt_sel   = pin_s.latched_controller_select;
         end
         bcc_pkg::BS_CMD:
         begin
            nxt_phase = ~phase_ff;
            if (cnt_ff != bcc_pkg::CNT_MAX)
               nxt_cnt = cnt_ff + 2'h1;
            if (cycle_end)
            begin
               // back to back cycles go straight to status
               if (start)
               begin
                  nxt_st  = bcc_pkg::BS_STATUS;
                  nxt_cyc = bcc_pkg::decode_cycle(pin_s);
               end
               else
                  nxt_st = bcc_pkg::BS_IDLE;
               nxt_phase = start;
            end
         end
      endcase
   end

   // command start delay: reads and writes differ only in compatible mode
   always_comb
   begin
      if (!compat)
         need = bcc_pkg::DLY_FAST;
      else if (bcc_pkg::is_write(nxt_cyc))
         need = bcc_pkg::DLY_CMP_WR;
      else
         need = bcc_pkg::DLY_CMP_RD;
   end

   // once started, a command stays on until the cycle ends
   always_comb
   begin
      nxt_cmd_on = 1'b0;
      if (nxt_st == bcc_pkg::BS_CMD && st_ff == bcc_pkg::BS_CMD && cmd_on_ff)
         nxt_cmd_on = 1'b1;
      else if (nxt_st == bcc_pkg::BS_CMD && nxt_cnt >= need)
         nxt_cmd_on = ~pin_s.command_delay;
   end

   // pick the strobe belonging to the cycle type
   always_comb
   begin
      onehot = '0;
      unique case (nxt_cyc)
         bcc_pkg::CYC_IRQ_ACK_STROBE:  onehot[4] = 1'b1;
         bcc_pkg::CYC_IORD:  onehot[3] = 1'b1;
         bcc_pkg::CYC_IOWR:  onehot[2] = 1'b1;
         bcc_pkg::CYC_MEMRD: onehot[1] = 1'b1;
         bcc_pkg::CYC_MEMWR: onehot[0] = 1'b1;
         default:            onehot = '0; // halt and idle codes: no strobe
      endcase
   end

   // strobes are low only while selected, enabled and started
   always_comb
   begin
      if (nxt_cmd_on && nxt_sel && enable_ok && nxt_st == bcc_pkg::BS_CMD)
         nxt_cmd = bcc_pkg::bcc_cmd_t'(~onehot);
      else
         nxt_cmd = bcc_pkg::bcc_cmd_t'({bcc_pkg::CMD_W{1'b1}});
      // only the bus grant may float the strobes, and only when compatible
      nxt_oe = ~compat | ~pin_s.shared_enable_input;
   end

   // latch and cascade strobes follow the state and cycle type, never the enables
   always_comb
   begin
      nxt_ale = (nxt_st == bcc_pkg::BS_STATUS) &&
                (nxt_cyc != bcc_pkg::CYC_HALT);
      nxt_cas = (nxt_st == bcc_pkg::BS_STATUS) &&
                (nxt_cyc == bcc_pkg::CYC_IRQ_ACK_STROBE);
   end

   // transceiver enable; fast writes open it already in the status state
   always_comb
   begin
      sel_now  = (nxt_st == bcc_pkg::BS_STATUS) ? pin_s.latched_controller_select
                                                : nxt_sel;
      want_xen = 1'b0;
      if (nxt_cyc != bcc_pkg::CYC_HALT && sel_now && enable_ok)
      begin
         if (nxt_st == bcc_pkg::BS_CMD)
            want_xen = 1'b1;
         else if (nxt_st == bcc_pkg::BS_STATUS)
            want_xen = bcc_pkg::is_write(nxt_cyc) && !compat;
      end
   end

   // direction is low only inside read cycles
   always_comb
   begin
      want_dir = 1'b1;
      if (nxt_st != bcc_pkg::BS_IDLE && bcc_pkg::is_read(nxt_cyc))
         want_dir = 1'b0;
   end

   // never move direction while enabled: the enable drops first and the
   // direction follows a clock later, costing two clocks of enable
   always_comb
   begin
      nxt_dir = xen_ff ? dir_ff : want_dir;
      nxt_xen = want_xen && (dir_ff == want_dir);
   end

   // bus state registers; reset is the idle state that ready low forces
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff    <= bcc_pkg::BS_IDLE;
         phase_ff <= 1'b0;
         cnt_ff   <= 2'h0;
         cyc_ff   <= bcc_pkg::CYC_IDLE1;
         sel_ff   <= 1'b0;
      end
      else if (clk_en)
      begin
         st_ff    <= nxt_st;
         phase_ff <= nxt_phase;
         cnt_ff   <= nxt_cnt;
         cyc_ff   <= nxt_cyc;
         sel_ff   <= nxt_sel;
      end
   end

   // command strobes and their drive enable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_on_ff <= 1'b0;
         cmd       <= bcc_pkg::bcc_cmd_t'({bcc_pkg::CMD_W{1'b1}});
         cmd_oe    <= 1'b0;
      end
      else if (clk_en)
      begin
         cmd_on_ff <= nxt_cmd_on;
         cmd       <= nxt_cmd;
         cmd_oe    <= nxt_oe;
      end
   end

   // latch and cascade strobes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_latch_strobe <= 1'b0;
         cascade_enable    <= 1'b0;
      end
      else if (clk_en)
      begin
         addr_latch_strobe <= nxt_ale;
         cascade_enable    <= nxt_cas;
      end
   end

   // transceiver enable and direction; command delay is not an input here
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         xen_ff <= 1'b0;
         dir_ff <= 1'b1;
      end
      else if (clk_en)
      begin
         xen_ff <= nxt_xen;
         dir_ff <= nxt_dir;
      end
   end

   assign transceiver_enable = xen_ff;
   assign transfer_direction = dir_ff;

endmodule

// [verification/bcc_ctrl_assertions.sv]
// port checks for the bus command controller, bound into its top module
module bcc_ctrl_chk (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire bcc_pkg::bcc_cmd_t cmd,
   input wire logic              cmd_oe,
   input wire logic              addr_latch_strobe,
   input wire logic              cascade_enable,
   input wire logic              transceiver_enable,
   input wire logic              transfer_direction
);
   // read-type and write-type strobes currently asserted
   wire logic rd_on = !cmd.irq_ack_strobe_n | !cmd.io_read_strobe_n | !cmd.mem_read_strobe_n;
   wire logic wr_on = !cmd.io_write_strobe_n | !cmd.mem_write_strobe_n;

   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // a cycle needs at least one command state before the next latch pulse
   a_ale_gap: assert property (addr_latch_strobe |=> !addr_latch_strobe [*2])
      else $error("address latch strobe repeated too soon");
   a_cascade_in_ale: assert property (cascade_enable |-> addr_latch_strobe)
      else $error("cascade enable outside the latch pulse");
   a_one_strobe: assert property ($onehot0(~cmd))
      else $error("more than one command strobe low");
   a_strobe_not_ale: assert property ((cmd != 5'h1F) |-> !addr_latch_strobe)
      else $error("command strobe low during status state");
   a_read_dir_low: assert property (rd_on |-> !transfer_direction)
      else $error("direction high during a read strobe");
   a_write_dir_high: assert property (wr_on |-> transfer_direction)
      else $error("direction low during a write strobe");
   // direction may only move once the transceiver has been off a full clock
   a_dir_enable_off: assert property ($changed(transfer_direction) |->
      !transceiver_enable && !$past(transceiver_enable))
      else $error("direction changed with transceiver enabled");
   a_float_quiet: assert property (!cmd_oe |-> cmd == 5'h1F)
      else $error("strobe asserted while floating");
endmodule

bind bcc_ctrl bcc_ctrl_chk bcc_ctrl_chk_inst (.pclk(pclk), .presetn(presetn), .cmd(cmd),
   .cmd_oe(cmd_oe), .addr_latch_strobe(addr_latch_strobe), .cascade_enable(cascade_enable),
   .transceiver_enable(transceiver_enable), .transfer_direction(transfer_direction));

// [verification/bcc_cpu_model.sv]
// processor-side model: drives status, select, delay, ready, strap and enable pins
module bcc_cpu_model (
   input  wire logic            pclk,
   output bcc_pkg::bcc_pin_in_t pins
);
   timeunit 1ns;
   timeprecision 1ps;

   // status idle, ready low from time zero so reset lands in idle
   initial pins = bcc_pkg::bcc_pin_in_t'(8'h69);

   // strap and enable only move while the bus is idle
   task automatic set_mode(input logic strap, input logic en);
      @(posedge pclk);
      pins.compat_timing_strap <= strap;
      pins.shared_enable_input <= en;
      repeat (6) @(posedge pclk);
   endtask

   // status for two clocks; ready stays high for hold clocks, delay for dly clocks but at most hold plus 8
   task automatic bus_cycle(input logic [2:0] code, input logic sel, input int hold,
                            input int dly);
      @(posedge pclk);
      {pins.mem_io_select, pins.status_line_one_n, pins.status_line_zero_n} <= code;
      pins.latched_controller_select <= sel;
      pins.command_delay <= (dly > 0);
      pins.ready_n <= 1'b1;
      for (int i = 1; i <= hold; i++)
      begin
         @(posedge pclk);
         if (i == 2)
            {pins.status_line_one_n, pins.status_line_zero_n} <= 2'h3;
         pins.command_delay <= (i < dly);
      end
      // a hold of 4 or more covers one wait state, which compatible writes need
      pins.ready_n <= 1'b0;
      repeat (8) @(posedge pclk);
      pins.command_delay <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
endmodule

// [verification/bcc_ctrl_tb_top.sv]
// self-checking bench for the bus command controller
module bcc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [7:0]           paddr;
   logic [31:0]          pwdata, prdata;
   logic                 cmd_oe, ale, cas, xen, dir;
   logic [4:0]           cmd, mask;
   bcc_pkg::bcc_pin_in_t pins;
   int                   failures, num_checks, cyc, n_ale, n_cas, n_xen, n_dir, n_oe, n_cmd;
   int                   ale_at, cmd_at, xen_at;
   logic [4:0]           cmd_q = 5'h1F;
   logic [3:0]           ctl_q = 4'h1;

   bcc_ctrl bcc_ctrl_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pins(pins), .cmd(cmd), .cmd_oe(cmd_oe),
      .addr_latch_strobe(ale), .cascade_enable(cas), .transceiver_enable(xen),
      .transfer_direction(dir));
   bcc_cpu_model bcc_cpu_model_inst (.pclk(pclk), .pins(pins));

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // edge counters; compared as differences across one cycle, except n_ale once after reset
   always @(posedge pclk)
   begin
      cyc++;
      n_ale += int'(ale & !ctl_q[3]);
      ale_at = (ale & !ctl_q[3]) ? cyc : ale_at;
      n_cas += int'(cas & !ctl_q[2]);
      n_xen += int'(xen & !ctl_q[1]);
      xen_at = (xen & !ctl_q[1]) ? cyc : xen_at;
      n_dir += int'(!dir & ctl_q[0]);
      n_oe += int'(!cmd_oe);
      n_cmd += int'((cmd_q & ~cmd) != 5'h0);
      mask = ((cmd_q & ~cmd) != 5'h0) ? (cmd_q & ~cmd) : mask;
      cmd_at = ((cmd_q & ~cmd) != 5'h0) ? cyc : cmd_at;
      {ctl_q, cmd_q} = {ale, cas, xen, dir, cmd};
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want)
      begin
         failures++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic print_verdict();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // one apb transfer; waits for pready as long as it takes, the watchdog ends a hang
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
   endtask

   // one bus cycle through the model, then compare with the reference
   task automatic run(input logic [2:0] code, input logic strap, input logic sel,
                      input logic en, input int hold, input int dly);
      int   a, m, d, r, o, c, bp;
      logic live, act, rd;
      if (strap !== pins.compat_timing_strap || en !== pins.shared_enable_input)
         bcc_cpu_model_inst.set_mode(strap, en);
      {a, m, d, r, o, c} = {n_ale, n_cas, n_xen, n_dir, n_oe, n_cmd};
      bcc_cpu_model_inst.bus_cycle(code, sel, hold, dly);
      live = (code[1:0] != 2'h3) && (code != 3'h4);
      rd = (code == 3'h0) || (code == 3'h1) || (code == 3'h5);
      act = live && sel && (strap ? !en : en);
      bp = (code == 3'h0) ? 4 : (code == 3'h1) ? 3 : (code == 3'h2) ? 2 : (code == 3'h5);
      check(n_ale - a, live);
      check(n_cas - m, code == 3'h0);
      check(n_dir - r, live && rd);
      check(n_oe - o != 0, strap && en);
      check(n_xen - d != 0, act);
      check(n_cmd - c, act && dly < hold);
      if (act && dly < hold)
         check(mask, 5'h1 << bp);
      if (act && dly == 0)
         check(cmd_at - ale_at, strap ? (rd ? 2 : 3) : 1);
      if (act && !rd && dly == 0)
         check(xen_at - ale_at, strap);
   endtask

   initial
   begin
      logic [31:0] rd;
      logic        err;
      logic        strap;
      int          w, dly;
      {presetn, clk_en, psel, penable, pwrite, paddr, pwdata} = {2'h1, 43'h0};
      w = $urandom(32'hFD24);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, bcc_pkg::REG_CTRL, 32'h0, rd, err);
      check(rd, 32'(bcc_pkg::CTRL_EN_RST) << bcc_pkg::CTRL_EN);
      apb(1'b0, 8'h10, 32'h0, rd, err);
      check(rd, 32'h0);
      check(err, 1'b1);
      apb(1'b1, bcc_pkg::REG_CTRL, (32'h1 << bcc_pkg::CTRL_CLR) | 32'h1, rd, err);
      apb(1'b0, bcc_pkg::REG_CYCLES, 32'h0, rd, err);
      check(rd, 32'h0);
      // no cycle may open on its own coming out of reset
      check(n_ale, 32'h0);
      // every code in both timings first, then random select and enable
      for (int i = 0; i < 40; i++)
      begin
         strap = (i < 16) ? i[3] : 1'($urandom_range(1, 0));
         w = $urandom_range(2, 0);
         dly = (i < 16) ? 0 : $urandom_range(3, 0);
         run((i < 16) ? i[2:0] : 3'($urandom_range(7, 0)), strap,
             (i < 16) || 1'($urandom_range(1, 0)),
             (i < 16) ? !strap : 1'($urandom_range(1, 0)), 6 + 2 * w + dly + 2 * strap, dly);
      end
      // ready arrives while the delay still holds the command back
      run(3'h1, 1'b0, 1'b1, 1'b1, 4, 14);
      apb(1'b0, bcc_pkg::REG_STATUS, 32'h0, rd, err);
      check(rd[7:6], 2'h0);
      check(rd[1], pins.compat_timing_strap);
      print_verdict();
   end

   // a hang is cut short well beyond the expected run length
   initial
   begin
      repeat (5000) @(posedge pclk);
      failures++;
      print_verdict();
   end
endmodule
